// >>> rtl/spd_top.sv
// Supply protection and diagnostic control for a dual section supply.
// Notes on behaviour
// R1: Two 4-bit output level fields, host writable.
// R2: Four diagnostic flags readable by host.
// R3: Flags read low with no failure present.
// R4: Flags: overtemp, overload A, overload B, supply-low.
// R5: Flags latch; clear after cause gone and read.
// R6: Interface logic resets automatically at power-on.
// R7: Lockout ignores writes, zeroes all configuration.
// R8: Supply-low flag set when supply below threshold.
// R9: Pulsed select one static clamp, zero pulsed.
// R10: Dynamic overload: 90 ms on, 900 ms off.
// R11: Repeat windows until a clean on-window.
// R12: Static clamp sets flag, drives fault pin low.
// R13: Host starts capacitive loads in static mode.
// R14: Overload relatch clears level bits, disables output.
// R15: Without overload relatch, output re-enables automatically.
// R16: Overtemp shuts converter and both regulators.
// R17: Thermal relatch clears both sections' level bits.
// R18: Without thermal relatch, outputs re-enable automatically.
// R19: Windows are clock-derived cycle counters.
`timescale 1ns/100ps
module spd_top #(
    parameter int unsigned ON_CYC  = spd_pkg::ON_WINDOW_CYC,
    parameter int unsigned OFF_CYC = spd_pkg::OFF_WINDOW_CYC
) (
    // Clock, reset and clock enable.
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    // Analog comparator inputs, asynchronous to the clock.
    input  wire logic       supply_lockout_i,
    input  wire logic       supply_low_i,
    input  wire logic       overtemp_i,
    input  wire logic [1:0] overload_i,
    // Register access from the serial interface logic.
    input  wire logic       level_wr_i,
    input  wire logic [7:0] level_wdata_i,
    input  wire logic       prot_wr_i,
    input  wire logic [1:0] pulsed_limit_select_i,
    input  wire logic       recov_wr_i,
    input  wire logic [1:0] overload_relatch_select_i,
    input  wire logic       thermal_relatch_select_i,
    input  wire logic       flag_rd_i,
    // Register contents.
    output logic [7:0]      output_level_register_o,
    output logic [3:0]      diag_flag_register_o,
    output logic [1:0]      pulsed_limit_select_o,
    output logic [1:0]      overload_relatch_select_o,
    output logic            thermal_relatch_select_o,
    // Power block controls.
    output logic [1:0]      output_enable_o,
    output logic            converter_enable_o,
    output logic            fault_pin_n_o
);

    // Two-stage synchronisers for the comparator inputs.
    logic [4:0] sync_1;
    logic [4:0] sync_2;
    logic       lockout;
    logic       supply_low;
    logic       overtemp;
    logic [1:0] overload;
    logic [1:0] retry_off;
    logic [1:0] retry_trip;
    logic       overtemp_rise;
    logic [1:0] overload_rise;
    logic       overtemp_q;
    logic [1:0] overload_q;
    logic       wr_ok;
    logic       rd_ok;

    // Comparator levels are analog and asynchronous, so sync them first.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync_1 <= 5'h00;
            sync_2 <= 5'h00;
        end else if (ce_i) begin
            sync_1 <= {supply_lockout_i, supply_low_i, overtemp_i,
                       overload_i};
            sync_2 <= sync_1;
        end
    end

    assign lockout    = sync_2[4];
    assign supply_low = sync_2[3];
    assign overtemp   = sync_2[2];
    assign overload   = sync_2[1:0];

    // Writes are refused for the whole lockout.
    assign wr_ok = !lockout; // R7

    // Reads during lockout are ignored too, so flags survive them.
    assign rd_ok = !lockout; // R7

    // Edge history for the relatch events.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            overtemp_q <= 1'b0;
            overload_q <= 2'h0;
        end else if (ce_i) begin
            overtemp_q <= overtemp;
            overload_q <= overload;
        end
    end

    assign overtemp_rise = overtemp && !overtemp_q;
    assign overload_rise = overload & ~overload_q;

    // One retry sequencer per section, only active in pulsed mode.
    spd_retry #(
        .ON_CYC  (ON_CYC),
        .OFF_CYC (OFF_CYC)
    ) u_retry_a (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .dynamic_i  (!pulsed_limit_select_o[0]), // R9
        .overload_i (overload[0]),
        .off_o      (retry_off[0]),
        .trip_o     (retry_trip[0])
    );

    spd_retry #(
        .ON_CYC  (ON_CYC),
        .OFF_CYC (OFF_CYC)
    ) u_retry_b (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .dynamic_i  (!pulsed_limit_select_o[1]), // R9
        .overload_i (overload[1]),
        .off_o      (retry_off[1]),
        .trip_o     (retry_trip[1])
    );

    // Output level register. Relatch events clear a section's nibble; an
    // event in the same cycle as a host write wins, so no trip is lost.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            output_level_register_o <= spd_pkg::LEVEL_RESET; // R6
        end else if (ce_i) begin
            if (lockout) begin
                output_level_register_o <= spd_pkg::LEVEL_RESET; // R7
            end else begin
                if (level_wr_i && wr_ok) begin
                    output_level_register_o <= level_wdata_i; // R1
                end
                if ((overload_rise[0] && overload_relatch_select_o[0])
                    || (overtemp_rise && thermal_relatch_select_o)) begin
                    output_level_register_o[spd_pkg::LEVEL_A_LSB +:
                        spd_pkg::LEVEL_W] <= 4'h0; // R14 R17
                end
                if ((overload_rise[1] && overload_relatch_select_o[1])
                    || (overtemp_rise && thermal_relatch_select_o)) begin
                    output_level_register_o[spd_pkg::LEVEL_B_LSB +:
                        spd_pkg::LEVEL_W] <= 4'h0; // R14 R17
                end
            end
        end
    end

    // Protection and recovery configuration registers.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pulsed_limit_select_o     <= spd_pkg::PULSED_RESET;
            overload_relatch_select_o <= spd_pkg::OL_RELATCH_RST;
            thermal_relatch_select_o  <= spd_pkg::TH_RELATCH_RST;
        end else if (ce_i) begin
            if (lockout) begin
                pulsed_limit_select_o     <= spd_pkg::PULSED_RESET; // R7
                overload_relatch_select_o <= spd_pkg::OL_RELATCH_RST;
                thermal_relatch_select_o  <= spd_pkg::TH_RELATCH_RST;
            end else begin
                if (prot_wr_i) begin
                    pulsed_limit_select_o <= pulsed_limit_select_i; // R9
                end
                if (recov_wr_i) begin
                    overload_relatch_select_o <= overload_relatch_select_i;
                    thermal_relatch_select_o  <= thermal_relatch_select_i;
                end
            end
        end
    end

    // Diagnostic flags. A flag clears on a read only once its cause has
    // gone; the cause being present sets it, so set always beats clear.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            diag_flag_register_o <= spd_pkg::FLAG_RESET; // R3
        end else if (ce_i) begin
            if (rd_ok && flag_rd_i && !overtemp) begin // R2
                diag_flag_register_o[spd_pkg::FLAG_OVERTEMP] <= 1'b0; // R5
            end
            if (rd_ok && flag_rd_i && !overload[0]) begin
                diag_flag_register_o[spd_pkg::FLAG_OVERLOAD_A] <= 1'b0;
            end
            if (rd_ok && flag_rd_i && !overload[1]) begin
                diag_flag_register_o[spd_pkg::FLAG_OVERLOAD_B] <= 1'b0;
            end
            if (rd_ok && flag_rd_i && !supply_low) begin
                diag_flag_register_o[spd_pkg::FLAG_SUPPLY_LOW] <= 1'b0;
            end
            if (overtemp) begin
                diag_flag_register_o[spd_pkg::FLAG_OVERTEMP] <= 1'b1; // R16
            end
            if (overload[0] || retry_trip[0]) begin
                diag_flag_register_o[spd_pkg::FLAG_OVERLOAD_A] <= 1'b1; // R12
            end
            if (overload[1] || retry_trip[1]) begin
                diag_flag_register_o[spd_pkg::FLAG_OVERLOAD_B] <= 1'b1; // R12
            end
            if (supply_low) begin
                diag_flag_register_o[spd_pkg::FLAG_SUPPLY_LOW] <= 1'b1; // R8
            end
        end
    end

    // Power controls. A section runs with a nonzero level, no lockout, no
    // overtemperature, outside its off window, and in relatch mode not
    // while the overload is still standing.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            output_enable_o    <= 2'h0;
            converter_enable_o <= 1'b0;
        end else if (ce_i) begin
            converter_enable_o <= !lockout && !overtemp; // R16 R18
            output_enable_o[0] <= !lockout && !overtemp // R15 R18
                && (output_level_register_o[3:0] != 4'h0)
                && !retry_off[0] // R10
                && !(overload[0] && overload_relatch_select_o[0]); // R14
            output_enable_o[1] <= !lockout && !overtemp
                && (output_level_register_o[7:4] != 4'h0)
                && !retry_off[1] // R10
                && !(overload[1] && overload_relatch_select_o[1]); // R14
        end
    end

    // Fault pin is low while either overload flag is latched.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            fault_pin_n_o <= 1'b1;
        end else if (ce_i) begin
            fault_pin_n_o <= !(overload[0] || overload[1]
                || diag_flag_register_o[spd_pkg::FLAG_OVERLOAD_A]
                || diag_flag_register_o[spd_pkg::FLAG_OVERLOAD_B]); // R12
        end
    end

    // An overtemperature keeps the converter off next cycle.
    overtemp_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && overtemp) |=> !converter_enable_o) // R16
        else $error("Converter on during overtemperature.");

    // A standing cause keeps its flag set through a read.
    flag_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && supply_low) |=> diag_flag_register_o[3]) // R8
        else $error("Supply low flag not set.");

    // Lockout zeroes the level register.
    lockout_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && lockout) |=> (output_level_register_o == 8'h00)) // R7
        else $error("Level bits kept during lockout.");

    // Relatch on overtemperature clears both nibbles.
    thermal_relatch_select_relatch_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && overtemp_rise && thermal_relatch_select_o)
        |=> (output_level_register_o == 8'h00)) // R17
        else $error("Thermal relatch left levels set.");

    // A flag with no cause clears on a read.
    flag_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && rd_ok && flag_rd_i && !overtemp)
        |=> !diag_flag_register_o[0]) // R5
        else $error("Overtemp flag not cleared by read.");

    // Fault pin goes low when section A overload is flagged.
    fault_pin_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && overload[0]) |=> !fault_pin_n_o) // R12
        else $error("Fault pin not low on overload.");

    // Off window disables the output.
    retry_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && retry_off[0]) |=> !output_enable_o[0]) // R10
        else $error("Output on during off window.");

    // Zero level keeps a section off.
    level_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && output_level_register_o[7:4] == 4'h0)
        |=> !output_enable_o[1]) // R1
        else $error("Output on with zero level.");

    // A latched flag holds until it is read.
    flag_latch_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && diag_flag_register_o[1] && !flag_rd_i)
        |=> diag_flag_register_o[1]) // R5
        else $error("Flag dropped without a read.");

    // Section B overload lands in its own flag bit.
    ovl_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && overload[1]) |=> diag_flag_register_o[2]) // R4 R12
        else $error("Overload B flag not set.");

    // Overtemperature lands in its own flag bit.
    ot_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && overtemp) |=> diag_flag_register_o[0]) // R4 R16
        else $error("Overtemp flag not set.");

    // With no failure a read leaves the flag low.
    low_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && rd_ok && flag_rd_i && !supply_low)
        |=> !diag_flag_register_o[3]) // R3
        else $error("Supply low flag high with no cause.");

    // A read during lockout clears nothing.
    read_lock_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && lockout && diag_flag_register_o[3])
        |=> diag_flag_register_o[3]) // R7
        else $error("Flag cleared during lockout.");

    // Lockout zeroes the configuration bits.
    lockout_cfg_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && lockout) |=> (pulsed_limit_select_o == 2'h0
            && overload_relatch_select_o == 2'h0
            && !thermal_relatch_select_o)) // R7
        else $error("Configuration kept during lockout.");

    // A plain host write lands whole in the level register.
    level_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && wr_ok && level_wr_i && !overtemp_rise
            && (overload_rise == 2'h0))
        |=> (output_level_register_o == $past(level_wdata_i))) // R1
        else $error("Level write lost.");

    // Overload relatch clears the section A nibble.
    ol_relatch_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && !lockout && overload_rise[0]
            && overload_relatch_select_o[0])
        |=> (output_level_register_o[3:0] == 4'h0)) // R14
        else $error("Overload relatch left level set.");

    // Without relatch a healthy section B runs again.
    auto_on_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && !lockout && !overtemp && !retry_off[1]
            && !overload_relatch_select_o[1]
            && output_level_register_o[7:4] != 4'h0)
        |=> output_enable_o[1]) // R15
        else $error("Output not re-enabled.");

    // Static clamp never shows an off window.
    static_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && pulsed_limit_select_o[0]) |=> !retry_off[0]) // R9
        else $error("Off window in static mode.");

    // The converter restarts once overtemperature is gone.
    conv_resume_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && !lockout && !overtemp) |=> converter_enable_o) // R18
        else $error("Converter not restarted.");

    // Fault pin returns high with no overload and no flag.
    fault_release_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ce_i && (overload == 2'h0)
            && (diag_flag_register_o[2:1] == 2'h0))
        |=> fault_pin_n_o) // R12
        else $error("Fault pin stuck low.");

endmodule : spd_top

// >>> rtl/spd_pkg.sv
// Package of constants for the supply protection and diagnostic block.
package spd_pkg;

    // Clock rate in kilohertz, used to turn milliseconds into cycles.
    localparam int unsigned CLK_KHZ         = 40000;

    // Retry window durations in milliseconds.
    localparam int unsigned ON_WINDOW_MS    = 90;
    localparam int unsigned OFF_WINDOW_MS   = 900;

    // Window lengths in clock cycles.
    localparam int unsigned ON_WINDOW_CYC   = ON_WINDOW_MS * CLK_KHZ;
    localparam int unsigned OFF_WINDOW_CYC  = OFF_WINDOW_MS * CLK_KHZ;

    // Output level register layout: section A low nibble, section B high.
    localparam int unsigned LEVEL_W         = 4;
    localparam int unsigned LEVEL_A_LSB     = 0;
    localparam int unsigned LEVEL_B_LSB     = 4;
    localparam logic [7:0]  LEVEL_RESET     = 8'h00;

    // Diagnostic flag register bit positions.
    localparam int unsigned FLAG_OVERTEMP   = 0;
    localparam int unsigned FLAG_OVERLOAD_A = 1;
    localparam int unsigned FLAG_OVERLOAD_B = 2;
    localparam int unsigned FLAG_SUPPLY_LOW = 3;
    localparam logic [3:0]  FLAG_RESET      = 4'h0;

    // Reset values of the configuration bits.
    localparam logic [1:0]  PULSED_RESET    = 2'h0;
    localparam logic [1:0]  OL_RELATCH_RST  = 2'h0;
    localparam logic        TH_RELATCH_RST  = 1'b0;

    // States of the per-section retry sequencer.
    typedef enum logic [1:0] {
        SPD_IDLE,
        SPD_ON_WIN,
        SPD_OFF_WIN
    } spd_retry_state_t;

endpackage : spd_pkg

// >>> rtl/spd_retry.sv
// Per-section overload retry sequencer with on and off windows.
`timescale 1ns/100ps
module spd_retry #(
    parameter int unsigned ON_CYC  = spd_pkg::ON_WINDOW_CYC,
    parameter int unsigned OFF_CYC = spd_pkg::OFF_WINDOW_CYC
) (
    // Clock and reset.
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    // Control and status.
    input  wire logic dynamic_i,
    input  wire logic overload_i,
    output logic      off_o,
    output logic      trip_o
);

    spd_pkg::spd_retry_state_t state;
    logic [31:0]               count;
    logic                      seen;

    // Off output shuts the stage down only during the off window.
    assign off_o  = (state == spd_pkg::SPD_OFF_WIN);
    // Trip pulses when a fresh overload starts the first on window.
    assign trip_o = ce_i && dynamic_i && overload_i
                    && (state == spd_pkg::SPD_IDLE);

    // Sequencer: idle, then on window, off window, repeat while overloaded.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= spd_pkg::SPD_IDLE;
            count <= 32'h0000_0000;
            seen  <= 1'b0;
        end else if (ce_i) begin
            case (state)
                spd_pkg::SPD_IDLE: begin
                    count <= 32'h0000_0000;
                    seen  <= 1'b0;
                    if (dynamic_i && overload_i) begin
                        state <= spd_pkg::SPD_ON_WIN; // R10
                        seen  <= 1'b1;
                    end
                end
                spd_pkg::SPD_ON_WIN: begin
                    if (overload_i) begin
                        seen <= 1'b1;
                    end
                    if (!dynamic_i) begin
                        state <= spd_pkg::SPD_IDLE;
                    end else if (count >= ON_CYC - 1) begin // R19
                        count <= 32'h0000_0000;
                        // A clean window ends the retry cycle.
                        if (seen || overload_i) begin
                            state <= spd_pkg::SPD_OFF_WIN; // R11
                        end else begin
                            state <= spd_pkg::SPD_IDLE; // R11
                        end
                    end else begin
                        count <= count + 32'h0000_0001;
                    end
                end
                spd_pkg::SPD_OFF_WIN: begin
                    if (!dynamic_i) begin
                        state <= spd_pkg::SPD_IDLE;
                    end else if (count >= OFF_CYC - 1) begin // R19
                        count <= 32'h0000_0000;
                        seen  <= 1'b0;
                        state <= spd_pkg::SPD_ON_WIN; // R11
                    end else begin
                        count <= count + 32'h0000_0001;
                    end
                end
                default: begin
                    state <= spd_pkg::SPD_IDLE;
                end
            endcase
        end
    end

    // The off window lasts more than one cycle unless dynamic mode or the clock enable drops.
    off_bound_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(off_o) |-> ##1 (off_o || !dynamic_i || !ce_i)) // R10
        else $error("Off window ended at once.");

endmodule : spd_retry

// >>> tb/spd_host_model.sv
// Host-side model that issues register accesses as one-cycle strobes.
`timescale 1ns/100ps
module spd_host_model (
    // Clock.
    input  wire logic       clk_i,
    // Register access strobes and write data.
    output logic            level_wr_o,
    output logic [7:0]      level_wdata_o,
    output logic            prot_wr_o,
    output logic [1:0]      pulsed_o,
    output logic            recov_wr_o,
    output logic [1:0]      ol_relatch_o,
    output logic            th_relatch_o,
    output logic            flag_rd_o
);
    // Strobes idle at time zero; data lines start with a pattern.
    initial begin
        {level_wr_o, prot_wr_o, recov_wr_o, flag_rd_o} = 4'h0;
        level_wdata_o = 8'h5a;
        {pulsed_o, ol_relatch_o, th_relatch_o} = 5'h15;
    end

    // One access of kind 0 level, 1 protection, 2 recovery, 3 flag read.
    // Data is scrambled after the strobe, so a design that samples a
    // released line sees garbage rather than a lucky stale value.
    task automatic access(input logic [1:0] kind, input logic [7:0] d);
        @(negedge clk_i);
        case (kind)
            2'h0: begin
                level_wr_o    = 1'b1;
                level_wdata_o = d;
            end
            2'h1: begin
                prot_wr_o = 1'b1;
                pulsed_o  = d[1:0];
            end
            2'h2: begin
                recov_wr_o   = 1'b1;
                ol_relatch_o = d[1:0];
                th_relatch_o = d[2];
            end
            default: flag_rd_o = 1'b1;
        endcase
        @(negedge clk_i);
        {level_wr_o, prot_wr_o, recov_wr_o, flag_rd_o} = 4'h0;
        level_wdata_o = ~level_wdata_o;
        {pulsed_o, ol_relatch_o, th_relatch_o} =
            ~{pulsed_o, ol_relatch_o, th_relatch_o};
    endtask : access
endmodule : spd_host_model

// >>> tb/spd_top_tb_top.sv
// Self-checking testbench for the supply protection and diagnostic block.
`timescale 1ns/100ps
module spd_top_tb_top;
    logic        clk, rst, lk, sl, ot;
    logic [1:0]  ovl, pls, overload_relatch_select, en;
    logic        lvw, pw, rw, th, rd, thq, conv, flt_n;
    logic [7:0]  lvd, lvl;
    logic [3:0]  flags;
    logic [1:0]  plsq, olrq;
    logic [11:0] q[$];
    int          n_fail, check_count;
    event        look;

    // Short windows keep the retry sequence within a brief run.
    spd_top #(.ON_CYC(10), .OFF_CYC(40)) i_dut (
        .clk_i(clk), .rst_i(rst), .ce_i(1'b1),
        .supply_lockout_i(lk), .supply_low_i(sl), .overtemp_i(ot),
        .overload_i(ovl), .level_wr_i(lvw), .level_wdata_i(lvd),
        .prot_wr_i(pw), .pulsed_limit_select_i(pls), .recov_wr_i(rw),
        .overload_relatch_select_i(overload_relatch_select), .thermal_relatch_select_i(th),
        .flag_rd_i(rd), .output_level_register_o(lvl),
        .diag_flag_register_o(flags), .pulsed_limit_select_o(plsq),
        .overload_relatch_select_o(olrq),
        .thermal_relatch_select_o(thq), .output_enable_o(en),
        .converter_enable_o(conv), .fault_pin_n_o(flt_n));

    spd_host_model h (
        .clk_i(clk), .level_wr_o(lvw), .level_wdata_o(lvd),
        .prot_wr_o(pw), .pulsed_o(pls), .recov_wr_o(rw),
        .ol_relatch_o(overload_relatch_select), .th_relatch_o(th), .flag_rd_o(rd));

    // Free-running clock, 25 ns period.
    initial clk = 1'b0;
    always #12.5 clk = ~clk;

    // Pick the observed output by selector; names follow the same code.
    function automatic logic [7:0] obs(input logic [3:0] s);
        case (s)
            4'h0: obs = lvl;
            4'h1: obs = {4'h0, flags};
            4'h2: obs = {6'h0, en};
            4'h3: obs = {7'h0, flt_n};
            4'h4: obs = {7'h0, conv};
            default: obs = {3'h0, plsq, olrq, thq};
        endcase
    endfunction : obs

    task automatic check(input logic [3:0] s, input logic [7:0] seen,
                         input logic [7:0] exp);
        string nm[6] = '{"level", "flags", "enable", "fault_n",
                         "converter", "config"};
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm[s], exp, seen);
        end
    endtask : check

    // The driver notes expectations; the watcher compares the oldest.
    task automatic note(input logic [3:0] s, input logic [7:0] v);
        q.push_back({s, v});
        ->look;
    endtask : note

    always @(look) begin
        while (q.size() > 0) begin
            check(q[0][11:8], obs(q[0][11:8]), q[0][7:0]);
            void'(q.pop_front());
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    task automatic rd_flags;
        h.access(2'h3, 8'h00);
        cyc(1);
    endtask : rd_flags

    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test

    // Watchdog: the full sequence needs well under two thousand cycles.
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        finish_test();
    end

    // Main sequence; comparator levels change only at falling edges.
    initial begin
        logic [31:0] lf;
        lf = 32'h3d39;
        {rst, lk, sl, ot, ovl} = 6'h20;
        cyc(8);
        rst = 1'b0;
        cyc(1);
        note(4'h0, 8'h00);
        note(4'h1, 8'h00);
        note(4'h3, 8'h01);
        note(4'h2, 8'h00);
        for (int i = 0; i < 6; i++) begin
            lf = lfsr(lf);
            h.access(2'h0, lf[7:0]);
            note(4'h0, lf[7:0]);
            cyc(1);
            note(4'h2, {6'h0, |lf[7:4], |lf[3:0]});
            h.access(2'h1, {6'h0, lf[9:8]});
            h.access(2'h2, {5'h0, lf[12:10]});
            note(4'h5, {3'h0, lf[9:8], lf[11:10], lf[12]});
        end
        h.access(2'h2, 8'h00);
        h.access(2'h1, 8'h00);
        h.access(2'h0, 8'h35);
        // Dynamic retry on section A with the overload held.
        ovl = 2'b01;
        cyc(8);
        note(4'h2, 8'h03);
        note(4'h1, 8'h02);
        cyc(22);
        note(4'h2, 8'h02);
        cyc(30);
        note(4'h2, 8'h03);
        cyc(20);
        note(4'h2, 8'h02);
        ovl = 2'b00;
        cyc(50);
        note(4'h2, 8'h03);
        cyc(30);
        note(4'h2, 8'h03);
        note(4'h1, 8'h02);
        rd_flags();
        note(4'h1, 8'h00);
        // Static clamp on section B: flag and fault pin, no shutdown.
        h.access(2'h1, 8'h03);
        ovl = 2'b10;
        cyc(5);
        note(4'h1, 8'h04);
        note(4'h3, 8'h00);
        cyc(55);
        note(4'h2, 8'h03);
        rd_flags();
        note(4'h1, 8'h04);
        ovl = 2'b00;
        cyc(5);
        note(4'h3, 8'h00);
        rd_flags();
        note(4'h1, 8'h00);
        note(4'h3, 8'h01);
        // Overload relatch on section A only.
        h.access(2'h2, 8'h01);
        ovl = 2'b01;
        cyc(5);
        note(4'h0, 8'h30);
        ovl = 2'b00;
        cyc(5);
        note(4'h2, 8'h02);
        h.access(2'h0, 8'h35);
        cyc(1);
        note(4'h2, 8'h03);
        rd_flags();
        // Over-temperature without relatch, then with it.
        h.access(2'h2, 8'h00);
        ot = 1'b1;
        cyc(5);
        note(4'h2, 8'h00);
        note(4'h4, 8'h00);
        note(4'h1, 8'h01);
        ot = 1'b0;
        cyc(5);
        note(4'h2, 8'h03);
        note(4'h1, 8'h01);
        rd_flags();
        note(4'h1, 8'h00);
        h.access(2'h2, 8'h04);
        ot = 1'b1;
        cyc(5);
        note(4'h0, 8'h00);
        ot = 1'b0;
        cyc(5);
        note(4'h2, 8'h00);
        h.access(2'h0, 8'h35);
        cyc(1);
        note(4'h2, 8'h03);
        rd_flags();
        // Supply low flag latches until gone and read.
        sl = 1'b1;
        cyc(5);
        note(4'h1, 8'h08);
        rd_flags();
        note(4'h1, 8'h08);
        sl = 1'b0;
        cyc(5);
        rd_flags();
        note(4'h1, 8'h00);
        // Lockout clears configuration and refuses writes.
        lk = 1'b1;
        cyc(5);
        note(4'h0, 8'h00);
        note(4'h5, 8'h00);
        note(4'h2, 8'h00);
        h.access(2'h0, 8'h77);
        note(4'h0, 8'h00);
        lk = 1'b0;
        cyc(5);
        h.access(2'h0, 8'h12);
        note(4'h0, 8'h12);
        cyc(2);
        finish_test();
    end
endmodule : spd_top_tb_top
